/* File: verilog/sac_pkg.sv */
// constants for the successive approximation converter sequencer
// assumes a 10 MHz system clock and an apb register bus with 32-bit data
package sac_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int STAB_TIME_NS  = 7000;
   localparam int STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam logic [3:0] SAMPLE_TICKS = 4'h3;
   localparam logic [3:0] CONV_TICKS   = 4'hE;
   localparam int RES_W  = 10;
   localparam int ADDR_W = 12;

   // ***************************************************************
   // register byte offsets
   // ***************************************************************
   localparam logic [11:0] OFS_CSR   = 12'h000;
   localparam logic [11:0] OFS_CR1   = 12'h004;
   localparam logic [11:0] OFS_CR2   = 12'h008;
   localparam logic [11:0] OFS_CR3   = 12'h00C;
   localparam logic [11:0] OFS_DRH   = 12'h010;
   localparam logic [11:0] OFS_DRL   = 12'h014;
   localparam logic [11:0] OFS_HTR   = 12'h018;
   localparam logic [11:0] OFS_LTR   = 12'h01C;
   localparam logic [5:0]  SLOT_PAGE = 6'h01;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int CSR_AWD_IE = 5;
   localparam int CSR_AWD    = 6;
   localparam int CSR_EOC    = 7;
   localparam int CR1_CONVERTER_ON_BIT   = 0;
   localparam int CR1_REPEAT_CONVERSIONS_BIT   = 1;
   localparam int CR1_SPS_LO = 4;
   localparam int CR2_SCAN   = 1;
   localparam int CR2_ALIGN  = 3;
   localparam int CR2_SRC    = 4;
   localparam int CR2_TRGEN  = 6;
   localparam int CR3_OVR    = 6;
   localparam int CR3_BUF    = 7;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [9:0] HTR_RST = 10'h3FF;
   localparam logic [9:0] LTR_RST = 10'h000;

   typedef enum logic [1:0] {
      SAC_OFF,
      SAC_STAB,
      SAC_READY,
      SAC_CONV
   } sac_state_type;

   // prescale select to master clock division factor, 2 up to 18
   function automatic logic [4:0] sac_div(input logic [2:0] sel);
      logic [4:0] d;
      d = 5'h02;
      unique case (sel)
         3'h0: d = 5'h02;
         3'h1: d = 5'h03;
         3'h2: d = 5'h04;
         3'h3: d = 5'h06;
         3'h4: d = 5'h08;
         3'h5: d = 5'h0A;
         3'h6: d = 5'h0C;
         3'h7: d = 5'h12;
      endcase
      return d;
   endfunction

endpackage

/* File: verilog/sac_top.sv */
// sequencer and register file around a 10-bit sar converter core
// assumes apb master on clk; analog core returns its result at end of
// each conversion; trigger inputs are synchronous single-clock signals
`timescale 1ns/100ps

module sac_top
   import sac_pkg::*;
#(
   parameter int NUM_CH = 16
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // start sources
   input  wire logic              timer_trigger_output,
   input  wire logic              external_trigger_pin,
   // analog core
   input  wire logic [RES_W-1:0]  adc_result,
   output logic                   adc_power,
   output logic                   adc_sample,
   output logic      [3:0]        adc_channel,
   // watchdog alert
   output logic                   awd_irq
);

   localparam int PW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
   localparam logic [PW-1:0] PTR_LAST = PW'(NUM_CH - 1);
   localparam logic [6:0]    STAB_LAST = 7'(STAB_CYCLES - 1);

   // ***************************************************************
   // state
   // ***************************************************************
   sac_state_type    state_r, state_nxt;
   logic [3:0]       input_select_field_r;
   logic             awd_ie_r, awd_r, eoc_r, ovr_r;
   logic             converter_on_bit_r, repeat_conversions_bit_r;
   logic [2:0]       clock_prescale_select_r;
   logic             scan_r, align_left_r, hw_trigger_enable_r;
   logic             trigger_source_select_r, buffered_mode_enable_r;
   logic [9:0]       htr_r, ltr_r, data_r;
   logic [7:0]       shadow_r;
   logic             pend_r;
   logic [4:0]       pre_cnt_r;
   logic [6:0]       stab_cnt_r;
   logic [3:0]       conv_cnt_r, conv_cnt_nxt;
   logic [3:0]       cur_ch_r;
   logic [PW-1:0]    ptr_r;
   logic             ext_d_r;
   logic [9:0]       result_ring_slots_r [NUM_CH];
   logic [NUM_CH-1:0] unread_r;
   logic [31:0]      prdata_r;
   logic             pready_r, pslverr_r, sample_r;

   // ***************************************************************
   // bus decode
   // ***************************************************************
   wire setup_ph  = psel & ~penable;
   wire access_ok = psel & penable & pready_r;
   wire wr_en     = access_ok & pwrite;
   wire rd_en     = access_ok & ~pwrite;
   wire hit_csr   = paddr == OFS_CSR;
   wire hit_cr1   = paddr == OFS_CR1;
   wire hit_cr2   = paddr == OFS_CR2;
   wire hit_cr3   = paddr == OFS_CR3;
   wire hit_drh   = paddr == OFS_DRH;
   wire hit_drl   = paddr == OFS_DRL;
   wire hit_htr   = paddr == OFS_HTR;
   wire hit_ltr   = paddr == OFS_LTR;
   wire [3:0] slot_idx = paddr[5:2];
   wire hit_slot  = (paddr[11:6] == SLOT_PAGE) && (paddr[1:0] == 2'b00)
                    && (32'(slot_idx) < NUM_CH);
   wire mapped    = hit_csr | hit_cr1 | hit_cr2 | hit_cr3 | hit_drh
                    | hit_drl | hit_htr | hit_ltr | hit_slot;

   // ***************************************************************
   // result formatting
   // ***************************************************************
   wire [7:0] hi_byte = align_left_r ? data_r[9:2]
                                     : {6'h00, data_r[9:8]};
   wire [7:0] lo_byte = align_left_r ? {data_r[1:0], 6'h00}
                                     : data_r[7:0];
   // first byte read depends on alignment; the other comes from shadow
   wire rd_first  = rd_en & (align_left_r ? hit_drh : hit_drl);
   wire rd_second = rd_en & (align_left_r ? hit_drl : hit_drh);
   wire [9:0] slot_q = result_ring_slots_r[slot_idx[PW-1:0]];
   wire [15:0] slot_al = align_left_r ? {slot_q, 6'h00}
                                      : {6'h00, slot_q};

   wire [31:0] rd_word =
      hit_csr  ? {24'h0, eoc_r, awd_r, awd_ie_r, 1'b0,
                  input_select_field_r} :
      hit_cr1  ? {25'h0, clock_prescale_select_r, 2'b00,
                  repeat_conversions_bit_r, converter_on_bit_r} :
      hit_cr2  ? {25'h0, hw_trigger_enable_r, 1'b0,
                  trigger_source_select_r, align_left_r, 1'b0,
                  scan_r, 1'b0} :
      hit_cr3  ? {24'h0, buffered_mode_enable_r, ovr_r, 6'h00} :
      hit_drh  ? {24'h0, (align_left_r ? hi_byte : shadow_r)} :
      hit_drl  ? {24'h0, (align_left_r ? shadow_r : lo_byte)} :
      hit_htr  ? {22'h0, htr_r} :
      hit_ltr  ? {22'h0, ltr_r} :
      hit_slot ? {16'h0, slot_al} : 32'h0000_0000;

   // ***************************************************************
   // converter clock and start conditions
   // ***************************************************************
   wire [4:0] div_last = sac_div(clock_prescale_select_r) - 5'h01;
   wire tick = converter_on_bit_r && (pre_cnt_r == div_last);

   wire csr_wr   = wr_en & hit_csr;
   wire cr1_wr   = wr_en & hit_cr1;
   wire converter_on_bit_set = cr1_wr & pwdata[CR1_CONVERTER_ON_BIT];
   wire sw_start = converter_on_bit_set & converter_on_bit_r;
   wire ext_rise = external_trigger_pin & ~ext_d_r;
   wire hw_event = hw_trigger_enable_r &
                   (trigger_source_select_r ? ext_rise
                                            : timer_trigger_output);
   wire start    = (state_r == SAC_READY) & (sw_start | hw_event);
   wire ch_change = csr_wr && (pwdata[3:0] != input_select_field_r)
                    && (state_r == SAC_CONV);
   wire conv_done = (state_r == SAC_CONV) && tick && !ch_change
                    && (conv_cnt_r == CONV_TICKS - 4'h1);
   wire scan_more = scan_r && (cur_ch_r < input_select_field_r);
   wire [3:0] first_ch = scan_r ? 4'h1 : input_select_field_r;

   // ***************************************************************
   // sequencer
   // ***************************************************************
   always_comb begin
      state_nxt    = state_r;
      conv_cnt_nxt = conv_cnt_r;
      unique case (state_r)
         SAC_OFF: begin
            if (converter_on_bit_set) begin
               state_nxt = SAC_STAB;
            end
         end
         SAC_STAB: begin
            if (stab_cnt_r == STAB_LAST) begin
               state_nxt = SAC_READY;
            end
         end
         SAC_READY: begin
            if (start) begin
               state_nxt    = SAC_CONV;
               conv_cnt_nxt = 4'h0;
            end
         end
         SAC_CONV: begin
            if (ch_change) begin
               conv_cnt_nxt = 4'h0;
            end else if (conv_done) begin
               conv_cnt_nxt = 4'h0;
               if (!scan_more && !repeat_conversions_bit_r) begin
                  state_nxt = SAC_READY;
               end
            end else if (tick) begin
               conv_cnt_nxt = conv_cnt_r + 4'h1;
            end
         end
      endcase
      if (cr1_wr && !pwdata[CR1_CONVERTER_ON_BIT]) begin
         state_nxt = SAC_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r    <= SAC_OFF;
         conv_cnt_r <= 4'h0;
         sample_r   <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         conv_cnt_r <= conv_cnt_nxt;
         // sample window counts converter clocks only
         sample_r   <= (state_nxt == SAC_CONV)
                       && (conv_cnt_nxt < SAMPLE_TICKS);
      end
   end

   always_ff @(posedge clk) begin
      // restart the divider on each start so sampling is whole ticks
      if (srst || !converter_on_bit_r || start || ch_change
          || pre_cnt_r == div_last) begin
         pre_cnt_r <= 5'h00;
      end else begin
         pre_cnt_r <= pre_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || state_r != SAC_STAB) begin
         stab_cnt_r <= 7'h00;
      end else begin
         stab_cnt_r <= stab_cnt_r + 7'h01;
      end
   end

   // channel walk: scan advances, continuous scan wraps back to 1
   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ch_r <= 4'h0;
      end else if (ch_change) begin
         cur_ch_r <= pwdata[3:0];
      end else if (start) begin
         cur_ch_r <= first_ch;
      end else if (conv_done) begin
         cur_ch_r <= scan_more ? cur_ch_r + 4'h1 : first_ch;
      end
   end

   // ***************************************************************
   // result ring
   // ***************************************************************
   wire ring_wr   = conv_done & buffered_mode_enable_r;
   wire [PW-1:0] ring_last = scan_r ? PW'(input_select_field_r - 4'h1)
                                    : PTR_LAST;
   wire ring_full = ptr_r == ring_last;

   always_ff @(posedge clk) begin
      if (srst || start) begin
         ptr_r <= '0;
      end else if (ring_wr) begin
         ptr_r <= (ring_full || ptr_r == PTR_LAST) ? '0 : ptr_r + 1'b1;
      end
   end

   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_slot
         wire hit_w = ring_wr && (ptr_r == PW'(i));
         wire hit_r = rd_en && hit_slot && (slot_idx == 4'(i));
         always_ff @(posedge clk) begin
            if (srst) begin
               result_ring_slots_r[i] <= 10'h000;
               unread_r[i]            <= 1'b0;
            end else begin
               if (hit_w) begin
                  result_ring_slots_r[i] <= adc_result;
               end
               // new data wins over a read in the same cycle
               unread_r[i] <= hit_w | (unread_r[i] & ~hit_r);
            end
         end
      end
   endgenerate

   wire ovr_hit  = ring_wr & unread_r[ptr_r];
   wire eoc_hit  = conv_done &
                   (buffered_mode_enable_r ? ring_full : 1'b1);
   wire awd_hit  = conv_done &&
                   ((adc_result >= htr_r) || (adc_result <= ltr_r));

   // ***************************************************************
   // data register and shadow
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         data_r   <= 10'h000;
         shadow_r <= 8'h00;
         pend_r   <= 1'b0;
      end else begin
         if (conv_done) begin
            data_r <= adc_result;
         end
         // a first read holds the shadow until the second read
         pend_r <= rd_first | (pend_r & ~rd_second);
         if (rd_first) begin
            shadow_r <= align_left_r ? lo_byte : hi_byte;
         end else if (!pend_r && conv_done) begin
            shadow_r <= align_left_r ? {adc_result[1:0], 6'h00}
                                     : {6'h00, adc_result[9:8]};
         end
      end
   end

   // ***************************************************************
   // control and status registers
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         input_select_field_r     <= 4'h0;
         awd_ie_r                 <= 1'b0;
         converter_on_bit_r       <= 1'b0;
         repeat_conversions_bit_r <= 1'b0;
         clock_prescale_select_r  <= 3'h0;
         scan_r                   <= 1'b0;
         align_left_r             <= 1'b0;
         trigger_source_select_r  <= 1'b0;
         hw_trigger_enable_r      <= 1'b0;
         buffered_mode_enable_r   <= 1'b0;
         htr_r                    <= HTR_RST;
         ltr_r                    <= LTR_RST;
      end else begin
         if (csr_wr) begin
            input_select_field_r <= pwdata[3:0];
            awd_ie_r             <= pwdata[CSR_AWD_IE];
         end
         if (cr1_wr) begin
            converter_on_bit_r       <= pwdata[CR1_CONVERTER_ON_BIT];
            repeat_conversions_bit_r <= pwdata[CR1_REPEAT_CONVERSIONS_BIT];
            clock_prescale_select_r  <= pwdata[CR1_SPS_LO +: 3];
         end
         if (wr_en && hit_cr2) begin
            scan_r                  <= pwdata[CR2_SCAN];
            align_left_r            <= pwdata[CR2_ALIGN];
            trigger_source_select_r <= pwdata[CR2_SRC];
            hw_trigger_enable_r     <= pwdata[CR2_TRGEN];
         end
         if (wr_en && hit_cr3) begin
            buffered_mode_enable_r <= pwdata[CR3_BUF];
         end
         if (wr_en && hit_htr) begin
            htr_r <= pwdata[9:0];
         end
         if (wr_en && hit_ltr) begin
            ltr_r <= pwdata[9:0];
         end
      end
   end

   // sticky flags: writing 0 clears, a hardware set in the same cycle wins
   always_ff @(posedge clk) begin
      if (srst) begin
         eoc_r <= 1'b0;
         awd_r <= 1'b0;
         ovr_r <= 1'b0;
      end else begin
         eoc_r <= eoc_hit | (eoc_r & ~(csr_wr & ~pwdata[CSR_EOC]));
         awd_r <= awd_hit | (awd_r & ~(csr_wr & ~pwdata[CSR_AWD]));
         ovr_r <= ovr_hit |
                  (ovr_r & ~(wr_en & hit_cr3 & ~pwdata[CR3_OVR]));
      end
   end

   // ***************************************************************
   // bus answer and outputs
   // ***************************************************************
   // one flopped answer per transfer: data captured in setup cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         ext_d_r   <= 1'b0;
         awd_irq   <= 1'b0;
      end else begin
         pready_r  <= setup_ph;
         pslverr_r <= setup_ph & ~mapped;
         if (setup_ph) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
         end
         ext_d_r <= external_trigger_pin;
         awd_irq <= awd_ie_r &
                    (awd_hit | (awd_r & ~(csr_wr & ~pwdata[CSR_AWD])));
      end
   end

   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign adc_power   = converter_on_bit_r;
   assign adc_sample  = sample_r;
   assign adc_channel = cur_ch_r;

endmodule // sac_top

/* File: test/sac_top_sva.sv */
// concurrent checks on the ports of the converter sequencer top
// assumes one clk domain with synchronous active-high srst
`timescale 1ns/100ps
module sac_top_sva
   import sac_pkg::*;
#(
   parameter int NUM_CH = 16
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              srst,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // start sources and core
   input wire logic              timer_trigger_output,
   input wire logic              external_trigger_pin,
   input wire logic [RES_W-1:0]  adc_result,
   input wire logic              adc_power,
   input wire logic              adc_sample,
   input wire logic [3:0]        adc_channel,
   input wire logic              awd_irq
);
   // ***************************************************************
   // helper counters
   // ***************************************************************
   logic [7:0] on_cnt_r;
   logic [5:0] smp_cnt_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // saturates so a long powered run never wraps back below the bound
   always_ff @(posedge clk) begin
      if (srst || !adc_power) begin
         on_cnt_r <= 8'h00;
      end else if (on_cnt_r != 8'hFF) begin
         on_cnt_r <= on_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      smp_cnt_r <= adc_sample ? smp_cnt_r + 6'h01 : 6'h00;
   end

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_start;
      !adc_sample ##1 adc_sample;
   endsequence

   // ***************************************************************
   // properties
   // ***************************************************************
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("ready missing in first access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   a_error_answer: assert property (pslverr |-> pready
      && (pwrite || prdata == 32'h0000_0000))
      else $error("error answer malformed");
   a_sample_powered: assert property (adc_sample |-> adc_power)
      else $error("sampling while unpowered");
   a_stab_wait: assert property (s_start |-> on_cnt_r >= STAB_CYCLES)
      else $error("conversion before stabilisation");
   a_sample_length: assert property ($fell(adc_sample) && adc_power
      |-> smp_cnt_r inside {6, 9, 12, 18, 24, 30, 36, 54})
      else $error("sampling not three converter clocks");
   a_chan_steady: assert property (adc_sample && $past(adc_sample)
      |-> $stable(adc_channel))
      else $error("channel moved during sampling");
   a_reset_quiet: assert property ($fell(srst)
      |-> !pready && !adc_power && !adc_sample && !awd_irq)
      else $error("outputs active after reset");
endmodule // sac_top_sva

bind sac_top sac_top_sva #(.NUM_CH(NUM_CH)) u_sva (.clk(clk), .srst(srst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_trigger_output(timer_trigger_output),
   .external_trigger_pin(external_trigger_pin), .adc_result(adc_result),
   .adc_power(adc_power), .adc_sample(adc_sample),
   .adc_channel(adc_channel), .awd_irq(awd_irq));

/* File: test/sac_top_test.sv */
// self-checking bench for the converter sequencer top
// assumes the checker is bound in; apb and core driven from here
`timescale 1ns/100ps
module sac_top_test
   import sac_pkg::*;
;
   logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        tmr = 0, ext = 0, pready, pslverr, err, irq_s;
   logic        adc_power, adc_sample, awd_irq;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q, stat;
   logic [9:0]  res = '0, r;
   logic [3:0]  adc_channel;
   int          miscompares = 0, check_count = 0, n, w, csr_v = 0;
   int          seed = 32'h649733af;
   int          dv[8] = '{2, 3, 4, 6, 8, 10, 12, 18};

   always #50 clk = ~clk;

   sac_top u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_trigger_output(tmr),
      .external_trigger_pin(ext), .adc_result(res), .adc_power(adc_power),
      .adc_sample(adc_sample), .adc_channel(adc_channel), .awd_irq(awd_irq));

   // ***************************************************************
   // helpers
   // ***************************************************************
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask

   task hang;
      miscompares++;
      $display("ERROR %0t wait ran out", $time);
      end_of_test();
   endtask

   // byte seen in a data register for a given alignment
   function automatic logic [31:0] byte_of(logic [9:0] v, logic lft,
                                           logic hi);
      logic [15:0] h;
      h = lft ? {v, 6'h00} : {6'h00, v};
      return hi ? h[15:8] : h[7:0];
   endfunction

   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) hang();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // poll for a finished conversion, then clear the eoc and awd flags
   task wait_eoc;
      int k;
      k = 0;
      do begin
         xfer(0, OFS_CSR, 0);
         k++;
      end while (q[CSR_EOC] !== 1'b1 && k < 120);
      if (k >= 120) hang();
      stat = q;
      irq_s = awd_irq;
      xfer(1, OFS_CSR, csr_v);
   endtask

   task rise(output int t);
      t = 0;
      while (adc_sample !== 1'b0 && t < 600) begin
         @(posedge clk);
         t++;
      end
      while (adc_sample !== 1'b1 && t < 600) begin
         @(posedge clk);
         t++;
      end
      if (t >= 600) hang();
   endtask

   task hold(output int t);
      t = 0;
      while (adc_sample === 1'b1 && t < 100) begin
         @(posedge clk);
         t++;
      end
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      xfer(0, OFS_HTR, 0);
      chk(q, 10'h3FF);
      xfer(0, OFS_LTR, 0);
      chk(q, 10'h000);
      xfer(0, 12'h030, 0);
      chk(err, 1);
      chk(q, 0);
      xfer(1, OFS_CR1, 1);
      // stabilisation is a fixed 70 cycles after power-up
      repeat (75) @(posedge clk);
      for (int s = 0; s < 8; s++) begin
         xfer(1, OFS_CR1, s * 16 + 1);
         rise(n);
         hold(w);
         chk(w, 3 * dv[s]);
         wait_eoc();
      end
      r = $random(seed);
      res <= r;
      xfer(1, OFS_CR1, 1);
      wait_eoc();
      xfer(0, OFS_DRL, 0);
      chk(q, byte_of(r, 0, 0));
      res <= ~r;
      xfer(1, OFS_CR1, 1);
      wait_eoc();
      xfer(0, OFS_DRH, 0);
      chk(q, byte_of(r, 0, 1));
      xfer(1, OFS_CR2, 8);
      xfer(1, OFS_CR1, 1);
      wait_eoc();
      xfer(0, OFS_DRH, 0);
      chk(q, byte_of(~r, 1, 1));
      xfer(0, OFS_DRL, 0);
      chk(q, byte_of(~r, 1, 0));
      for (int t = 0; t < 2; t++) begin
         xfer(1, OFS_CR2, 64 + 16 * t);
         tmr <= (t == 0);
         ext <= (t == 1);
         @(posedge clk);
         tmr <= 1'b0;
         wait_eoc();
         ext <= 1'b0;
      end
      xfer(1, OFS_HTR, 10'h200);
      xfer(1, OFS_LTR, 10'h100);
      csr_v = 32'h20;
      for (int i = 0; i < 3; i++) begin
         res <= (i == 0) ? 10'h200 : (i == 1) ? 10'h1FF : 10'h100;
         xfer(1, OFS_CSR, csr_v);
         xfer(1, OFS_CR1, 1);
         wait_eoc();
         chk(stat[CSR_AWD], i != 1);
         chk(irq_s, i != 1);
      end
      xfer(1, OFS_CR1, 3);
      rise(n);
      rise(n);
      chk(n, 14 * dv[0]);
      xfer(1, OFS_CR1, 1);
      // let the conversion in flight finish before watching for more
      repeat (40) @(posedge clk);
      w = 0;
      repeat (60) begin
         @(posedge clk);
         w += adc_sample;
      end
      chk(w, 0);
      wait_eoc();
      csr_v = 5;
      xfer(1, OFS_CSR, csr_v);
      xfer(1, OFS_CR1, 1);
      rise(n);
      hold(w);
      csr_v = 6;
      xfer(1, OFS_CSR, csr_v);
      rise(n);
      chk(adc_channel, 4'h6);
      wait_eoc();
      csr_v = 3;
      xfer(1, OFS_CSR, csr_v);
      xfer(1, OFS_CR2, 2);
      xfer(1, OFS_CR3, 8'h80);
      xfer(1, OFS_CR1, 3);
      for (int k = 0; k < 5; k++) begin
         rise(n);
         chk(adc_channel, k % 3 + 1);
      end
      xfer(1, OFS_CR1, 1);
      wait_eoc();
      xfer(0, OFS_CR3, 0);
      chk(q[CR3_OVR], 1'h1);
      xfer(0, 12'h040, 0);
      chk(q, {22'h00_0000, res});
      end_of_test();
   end
endmodule // sac_top_test
